// ===== rtl/wdt_rst_consts.svh
`ifndef WDT_RST_CONSTS_SVH
`define WDT_RST_CONSTS_SVH

// ****************************************************************
// register indices (byte address = 4 * index)
// ****************************************************************
`define RSTAT_OFS     6'h00
`define RCTRL_OFS     6'h01
`define WDT_BASE      6'h04
`define WCTRL_OFS     6'h00
`define WWIN_OFS      6'h01
`define WSTAT_OFS     6'h02
`define CCP_IDX       6'h08

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define SW_FLAG_BIT   5
`define DBG_FLAG_BIT  4
`define DOG_FLAG_BIT  3
`define BO_FLAG_BIT   2
`define PIN_FLAG_BIT  1
`define PU_FLAG_BIT   0
`define FLAGS_MSB     5
`define RSTAT_RESET   8'h01
`define TRIG_BIT      0
`define LEN_MSB       5
`define LEN_LSB       2
`define EN_BIT        1
`define UNLOCK_BIT    0
`define PEND_BIT      0
`define LEN_RESET     4'h0
`define CCP_KEY       8'hA5

// ****************************************************************
// timing
// ****************************************************************
`define CLK_MHZ       200
`define DOG_PULSE_NS  500
`define DOG_PULSE_CYC ((`DOG_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define EXT_MIN_NS    100
`define EXT_MIN_CYC   ((`EXT_MIN_NS * `CLK_MHZ + 999) / 1000)
`define CCP_WIN_CYC   4

`endif

// ===== rtl/wdt_rst_pkg.sv
package wdt_rst_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [13:0] tick_cnt_t;

  typedef enum logic [1:0] {
    PH_OFF,
    PH_CLOSED,
    PH_OPEN
  } wd_phase_e;

  // length code to count of 1 kHz ticks; reserved codes act as the longest
  function automatic tick_cnt_t len_ticks(input logic [3:0] code);
    case (code)
      4'h0:    len_ticks = 14'd8;
      4'h1:    len_ticks = 14'd16;
      4'h2:    len_ticks = 14'd32;
      4'h3:    len_ticks = 14'd64;
      4'h4:    len_ticks = 14'd125;
      4'h5:    len_ticks = 14'd250;
      4'h6:    len_ticks = 14'd500;
      4'h7:    len_ticks = 14'd1000;
      4'h8:    len_ticks = 14'd2000;
      4'h9:    len_ticks = 14'd4000;
      default: len_ticks = 14'd8000;
    endcase
  endfunction

endpackage

// ===== rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  // first stage is read by the second stage only
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta[i] <= 1'b0;
        q_o[i]  <= 1'b0;
      end else if (ce_i) begin
        meta[i] <= d_i[i];
        q_o[i]  <= meta[i];
      end
    end
  end

endmodule

`default_nettype wire

// ===== rtl/window_timer.sv
`timescale 1ns/10ps
`default_nettype none

module window_timer
  import wdt_rst_pkg::*;
(
  // clock and control
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       tick_i,
  // configuration
  input  wire logic       enable_i,
  input  wire logic       window_i,
  input  wire logic [3:0] open_len_i,
  input  wire logic [3:0] closed_len_i,
  // restart and timeout
  input  wire logic       restart_i,
  output var  logic       bite_o
);

  wd_phase_e phase;
  tick_cnt_t cnt;
  tick_cnt_t next_cnt;

  assign next_cnt = cnt + 14'd1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase  <= PH_OFF;
      cnt    <= '0;
      bite_o <= 1'b0;
    end else if (ce_i) begin
      bite_o <= 1'b0;
      if (!enable_i) begin
        phase <= PH_OFF;
        cnt   <= '0;
      end else begin
        case (phase)
          PH_OFF: begin
            cnt   <= '0;
            phase <= window_i ? PH_CLOSED : PH_OPEN;
          end
          PH_CLOSED: begin
            if (restart_i) begin
              bite_o <= 1'b1;
              phase  <= PH_OFF;
            end else if (tick_i) begin
              if (next_cnt >= len_ticks(closed_len_i)) begin
                cnt   <= '0;
                phase <= PH_OPEN;
              end else begin
                cnt <= next_cnt;
              end
            end
          end
          PH_OPEN: begin
            if (restart_i) begin
              phase <= PH_OFF;
            end else if (tick_i) begin
              if (next_cnt >= len_ticks(open_len_i)) begin
                bite_o <= 1'b1;
                phase  <= PH_OFF;
              end else begin
                cnt <= next_cnt;
              end
            end
          end
          default: phase <= PH_OFF;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ===== rtl/watchdog_and_reset_control.sv
// Functional notes
// - pin reset held while pin stays low
// - watchdog reset lasts 100 clocks (500 ns)
// - software reset issued within two clocks
// - cpu halted between soft request and reset
// - debug reset only from debug port pin
// - one cause flag per reset source
// - cause flags cleared by power-up or write-one
// - power-up flag cleared only by write-one
// - cause bits 7:6 read zero
// - trigger bit resets, cleared when reset issued
// - trigger write needs change protection window
// - eleven timeout lengths, default from fuses
// - normal mode bites unless restarted in time
// - restart in closed window causes reset
// - open window follows closed window directly
// - watchdog runs regardless of cpu state
// - counter advances on 1 kHz tick
// - watchdog writes need change protection window
// - config accepted only with unlock bit set
// - lock fuse freezes watchdog control register
// - lock freezes closed length, not window enable
// - open length field bits 5:2 selects timeout
// - control bit 1 enables the watchdog
// - sync pending until synced while enabled
`include "wdt_rst_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module watchdog_and_reset_control
  import wdt_rst_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // reset sources from pins
  input  wire logic        ext_rst_n_i,
  input  wire logic        bod_i,
  input  wire logic        dbg_rst_i,
  // cpu side
  input  wire logic        wdr_i,
  output var  logic        cpu_halt_o,
  output var  logic        sys_rst_o,
  // low power oscillator and fuses
  input  wire logic        lp_tick_i,
  input  wire logic        lock_fuse_i,
  input  wire logic [3:0]  per_fuse_i,
  input  wire logic [3:0]  closed_window_len_sel_fuse_i,
  input  wire logic        en_fuse_i,
  input  wire logic        wen_fuse_i
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [14:0] pins_s;
  logic        ext_n_s;
  logic        bod_s;
  logic        dbg_s;
  logic        tick_s;
  logic        lock_s;
  logic [3:0]  per_s;
  logic [3:0]  closed_window_len_sel_s;
  logic        en_s;
  logic        wen_s;

  pin_sync #(
    .W (15)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({ext_rst_n_i, bod_i, dbg_rst_i, lp_tick_i, lock_fuse_i,
             per_fuse_i, closed_window_len_sel_fuse_i, en_fuse_i, wen_fuse_i}),
    .q_o   (pins_s)
  );

  assign {ext_n_s, bod_s, dbg_s, tick_s, lock_s, per_s, closed_window_len_sel_s, en_s, wen_s} = pins_s;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    hit = (adr[7:2] == idx) && (adr[1:0] == 2'h0);
  endfunction

  logic       req;
  logic       wr;
  logic [7:0] wdat;
  logic       wr_rstat;
  logic       wr_rctrl;
  logic       wr_wctrl;
  logic       wr_wwin;
  logic       wr_ccp;
  logic       ccp_open;
  logic [2:0] ccp_cnt;

  assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr       = req && wb_we_i && wb_sel_i[0];
  assign wdat     = wb_dat_i[7:0];
  assign wr_rstat = wr && hit(wb_adr_i, `RSTAT_OFS);
  assign wr_rctrl = wr && hit(wb_adr_i, `RCTRL_OFS);
  assign wr_wctrl = wr && hit(wb_adr_i, `WDT_BASE + `WCTRL_OFS);
  assign wr_wwin  = wr && hit(wb_adr_i, `WDT_BASE + `WWIN_OFS);
  assign wr_ccp   = wr && hit(wb_adr_i, `CCP_IDX);
  assign ccp_open = (ccp_cnt != 3'h0);

  // ****************************************************************
  // change protection window
  // ****************************************************************
  // the key opens a short window; any protected write must land in it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ccp_cnt <= 3'h0;
    end else if (ce_i) begin
      if (wr_ccp && wdat == `CCP_KEY) begin
        ccp_cnt <= 3'(`CCP_WIN_CYC);
      end else if (ccp_open) begin
        ccp_cnt <= ccp_cnt - 3'h1;
      end
    end
  end

  // ****************************************************************
  // pin reset qualification
  // ****************************************************************
  logic [7:0] ext_cnt;
  logic       ext_hold;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_cnt  <= 8'h00;
      ext_hold <= 1'b0;
    end else if (ce_i) begin
      if (ext_n_s) begin
        ext_cnt  <= 8'h00;
        ext_hold <= 1'b0;
      end else if (ext_cnt >= 8'(`EXT_MIN_CYC - 1)) begin
        ext_hold <= 1'b1;
      end else begin
        ext_cnt <= ext_cnt + 8'h01;
      end
    end
  end

  // ****************************************************************
  // watchdog configuration
  // ****************************************************************
  logic [3:0] open_len;
  logic [3:0] closed_len;
  logic       dog_en;
  logic       win_en;
  logic [1:0] load_wait;
  logic       fuse_load;

  // fuses are caught two clocks after release, once the synchronisers hold them
  assign fuse_load = (load_wait == 2'h2) || sys_rst_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_wait <= 2'h0;
    end else if (ce_i && load_wait != 2'h3) begin
      load_wait <= load_wait + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      open_len <= `LEN_RESET;
      dog_en   <= 1'b0;
    end else if (ce_i) begin
      if (fuse_load) begin
        open_len <= per_s;
        dog_en   <= en_s;
      end else if (wr_wctrl && ccp_open && wdat[`UNLOCK_BIT] && !lock_s) begin
        open_len <= wdat[`LEN_MSB:`LEN_LSB];
        dog_en   <= wdat[`EN_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      closed_len <= `LEN_RESET;
      win_en     <= 1'b0;
    end else if (ce_i) begin
      if (fuse_load) begin
        closed_len <= closed_window_len_sel_s;
        win_en     <= wen_s;
      end else if (wr_wwin && ccp_open && wdat[`UNLOCK_BIT]) begin
        if (!lock_s) begin
          closed_len <= wdat[`LEN_MSB:`LEN_LSB];
        end
        win_en <= wdat[`EN_BIT];
      end
    end
  end

  // ****************************************************************
  // sync pending flag
  // ****************************************************************
  logic tick_d;
  logic tick_rise;
  logic sync_pending;
  logic cfg_wr;

  assign tick_rise = tick_s && !tick_d;
  assign cfg_wr    = (wr_wctrl || wr_wwin) && ccp_open;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_d <= 1'b0;
    end else if (ce_i) begin
      tick_d <= tick_s;
    end
  end

  // a new write restarts the wait even if an older one completes now
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_pending <= 1'b0;
    end else if (ce_i) begin
      if (cfg_wr) begin
        sync_pending <= 1'b1;
      end else if (tick_rise && dog_en) begin
        sync_pending <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // watchdog counter and reset pulse
  // ****************************************************************
  logic       bite;
  logic [7:0] dog_cnt;
  logic       dog_act;

  assign dog_act = (dog_cnt != 8'h00);

  // counter runs on its own tick whether or not the cpu executes
  window_timer u_timer (
    .clk_i        (clk_i),
    .rst_i        (rst_i || sys_rst_o),
    .ce_i         (ce_i),
    .tick_i       (tick_rise),
    .enable_i     (dog_en),
    .window_i     (win_en),
    .open_len_i   (open_len),
    .closed_len_i (closed_len),
    .restart_i    (wdr_i && !cpu_halt_o),
    .bite_o       (bite)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dog_cnt <= 8'h00;
    end else if (ce_i) begin
      if (bite) begin
        dog_cnt <= 8'(`DOG_PULSE_CYC);
      end else if (dog_act) begin
        dog_cnt <= dog_cnt - 8'h01;
      end
    end
  end

  // ****************************************************************
  // software reset trigger
  // ****************************************************************
  logic soft_trig;
  logic soft_go;

  assign soft_go = wr_rctrl && ccp_open && wdat[`TRIG_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_trig <= 1'b0;
    end else if (ce_i) begin
      if (soft_go) begin
        soft_trig <= 1'b1;
      end else if (soft_trig) begin
        soft_trig <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // reset combine and cause flags
  // ****************************************************************
  logic       next_rst;
  logic [5:0] cause;
  logic [5:0] src;
  logic [5:0] next_flags;

  // debug source enters only through its pin, no register reaches it
  assign src = {soft_trig, dbg_s, bite, bod_s, ext_hold, 1'b0};
  assign next_rst = soft_trig || dbg_s || dog_act || bod_s || ext_hold;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_rst_o  <= 1'b0;
      cpu_halt_o <= 1'b0;
    end else if (ce_i) begin
      sys_rst_o  <= next_rst;
      cpu_halt_o <= next_rst || soft_go;
    end
  end

  // set wins over a write-one clear arriving in the same cycle
  always_comb begin
    next_flags = cause;
    if (wr_rstat) begin
      next_flags = cause & ~wdat[`FLAGS_MSB:0];
    end
    next_flags = next_flags | src;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause <= 6'(`RSTAT_RESET);
    end else if (ce_i) begin
      cause <= next_flags;
    end
  end

  // ****************************************************************
  // bus answer
  // ****************************************************************
  byte_t rdat;

  always_comb begin
    rdat = 8'h00;
    if (hit(wb_adr_i, `RSTAT_OFS)) begin
      rdat = {2'b00, cause};
    end else if (hit(wb_adr_i, `RCTRL_OFS)) begin
      rdat = {7'h00, soft_trig};
    end else if (hit(wb_adr_i, `WDT_BASE + `WCTRL_OFS)) begin
      rdat = {2'b00, open_len, dog_en, 1'b0};
    end else if (hit(wb_adr_i, `WDT_BASE + `WWIN_OFS)) begin
      rdat = {2'b00, closed_len, win_en, 1'b0};
    end else if (hit(wb_adr_i, `WDT_BASE + `WSTAT_OFS)) begin
      rdat = {7'h00, sync_pending};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= req;
      wb_dat_o <= {24'h00_0000, rdat};
    end
  end

endmodule

`default_nettype wire

// ===== bench/wdt_rst_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdt_rst_consts.svh"

module wdt_rst_chk (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register bus
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  // reset sources and outputs
  input  wire logic        ext_rst_n_i,
  input  wire logic        bod_i,
  input  wire logic        dbg_rst_i,
  input  wire logic        cpu_halt_o,
  input  wire logic        sys_rst_o
);
  localparam int DOG_CYC = `DOG_PULSE_CYC;

  // ****************************************************************
  // helper counters
  // ****************************************************************
  logic [7:0] low_cnt;
  logic [7:0] rst_len;
  logic [3:0] quiet;

  always_ff @(posedge clk_i) begin
    if (rst_i || ext_rst_n_i) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !sys_rst_o) rst_len <= 8'h00;
    else if (rst_len != 8'hFF) rst_len <= rst_len + 8'h01;
  end

  // level sources keep a reset long, so pulse lengths are judged only once they are quiet
  always_ff @(posedge clk_i) begin
    if (rst_i || !ext_rst_n_i || bod_i || dbg_rst_i) quiet <= 4'h0;
    else if (quiet != 4'hF) quiet <= quiet + 4'h1;
  end

  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence soft_req;
    $rose(cpu_halt_o) && !sys_rst_o && ext_rst_n_i && !bod_i && !dbg_rst_i;
  endsequence
  sequence one_pulse;
    sys_rst_o ##1 !sys_rst_o;
  endsequence
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  halt_then_rst_a: assert property (soft_req |=> one_pulse)
    else $error("halt not followed by a one-cycle reset");
  pin_hold_a: assert property (low_cnt > 8'h18 |-> sys_rst_o)
    else $error("pin held low without system reset");
  dog_len_a: assert property ($fell(sys_rst_o) && quiet == 4'hF && rst_len > 8'h01
                              |-> rst_len == DOG_CYC)
    else $error("watchdog reset pulse has wrong length");
  rst_bound_a: assert property (sys_rst_o && quiet == 4'hF |-> rst_len <= DOG_CYC)
    else $error("reset stays too long with no level source");
  level_src_a: assert property ((bod_i || dbg_rst_i) [*5] |-> sys_rst_o)
    else $error("level source does not hold system reset");
  cause_rsv_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00
                                |-> wb_dat_o[31:6] == 26'h0)
    else $error("reserved cause bits read nonzero");
  trig_clear_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 && !cpu_halt_o
                                 |-> wb_dat_o == 32'h0)
    else $error("trigger bit reads set outside a pending reset");
  ack_next_a: assert property (bus_req |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
endmodule

bind watchdog_and_reset_control wdt_rst_chk chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ext_rst_n_i(ext_rst_n_i), .bod_i(bod_i), .dbg_rst_i(dbg_rst_i),
  .cpu_halt_o(cpu_halt_o), .sys_rst_o(sys_rst_o)
);
`default_nettype wire

// ===== bench/cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdt_rst_consts.svh"

module cpu_model (
  // clock
  input  wire logic        clk_i,
  // wishbone master
  output var  logic        wb_cyc_o,
  output var  logic        wb_stb_o,
  output var  logic        wb_we_o,
  output var  logic [7:0]  wb_adr_o,
  output var  logic [3:0]  wb_sel_o,
  output var  logic [31:0] wb_dat_o,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i,
  // restart instruction
  output var  logic        wdr_o
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'hFF;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
    wdr_o    = 1'b0;
  end

  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // released lines show the inverse so a stale value never looks valid
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'h1;
    wb_dat_o <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_adr_o <= ~adr;
    wb_dat_o <= ~{24'h000000, d};
  endtask

  // key write, then the guarded write as the next bus cycle, inside the window
  task automatic prot_wr(input logic [7:0] adr, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, {`CCP_IDX, 2'b00}, `CCP_KEY, q);
    bus(1'b1, adr, d, q);
  endtask

  task automatic restart();
    @(posedge clk_i);
    wdr_o <= 1'b1;
    @(posedge clk_i);
    wdr_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdt_rst_consts.svh"

module tb_top;
  localparam logic [7:0] a_cause = {`RSTAT_OFS, 2'b00};
  localparam logic [7:0] a_soft  = {`RCTRL_OFS, 2'b00};
  localparam logic [7:0] a_ctrl  = {`WDT_BASE + `WCTRL_OFS, 2'b00};
  localparam logic [7:0] a_win   = {`WDT_BASE + `WWIN_OFS, 2'b00};
  localparam logic [7:0] a_stat  = {`WDT_BASE + `WSTAT_OFS, 2'b00};

  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wdr_i, cpu_halt_o, sys_rst_o;
  logic ext_rst_n_i, bod_i, dbg_rst_i, lp_tick_i, lock_fuse_i, tick_run;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, tdiv;
  logic [31:0] wb_dat_i, wb_dat_o;
  int fail_count = 0;
  int n_checks = 0;

  watchdog_and_reset_control uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_rst_n_i(ext_rst_n_i), .bod_i(bod_i),
    .dbg_rst_i(dbg_rst_i), .wdr_i(wdr_i), .cpu_halt_o(cpu_halt_o), .sys_rst_o(sys_rst_o),
    .lp_tick_i(lp_tick_i), .lock_fuse_i(lock_fuse_i), .per_fuse_i(4'h3),
    .closed_window_len_sel_fuse_i(4'h2), .en_fuse_i(1'b0), .wen_fuse_i(1'b0));

  cpu_model cpu (
    .clk_i(clk_i), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i),
    .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i), .wb_dat_i(wb_dat_o),
    .wb_ack_i(wb_ack_o), .wdr_o(wdr_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // one slow tick every 16 clocks keeps the long timeouts short
  always @(posedge clk_i) begin
    if (rst_i) begin
      tdiv <= 4'h0;
      lp_tick_i <= 1'b0;
    end else begin
      tdiv <= tdiv + 4'h1;
      lp_tick_i <= tick_run & tdiv[3];
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    cpu.bus(1'b0, a, 8'h00, q);
    chk(what, exp, q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    cpu.bus(1'b1, a, d, q);
  endtask

  task automatic no_rst(input int n, input string what);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      seen = seen | sys_rst_o;
    end
    chk(what, 32'h0, {31'h0, seen});
  endtask

  task automatic bite(input int lim, input string what);
    int t;
    t = 0;
    while (sys_rst_o !== 1'b1 && t < lim) begin
      @(posedge clk_i);
      t++;
    end
    chk(what, 32'h1, {31'h0, sys_rst_o});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_boot();
    rd(a_cause, 32'h01, "cause after power-up");
    rd(8'hFC, 32'h0, "unmapped read");
    rd(a_soft, 32'h0, "trigger idle");
    rd(a_ctrl, 32'h0C, "fuse open length");
    rd(a_win, 32'h08, "fuse closed length");
  endtask

  task automatic t_pin();
    @(posedge clk_i);
    ext_rst_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    ext_rst_n_i <= 1'b1;
    no_rst(15, "short pin pulse");
    rd(a_cause, 32'h01, "cause after short pin");
    ext_rst_n_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    chk("pin held", 32'h1, {31'h0, sys_rst_o});
    ext_rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("pin released", 32'h0, {31'h0, sys_rst_o});
  endtask

  task automatic t_levels();
    @(posedge clk_i);
    bod_i <= 1'b1;
    dbg_rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    bod_i <= 1'b0;
    dbg_rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(a_cause, 32'h17, "cause after two sources");
  endtask

  task automatic t_w1c();
    wr(a_cause, 8'h02);
    rd(a_cause, 32'h15, "pin flag cleared");
    wr(a_cause, 8'hC0);
    rd(a_cause, 32'h15, "reserved write");
    wr(a_cause, 8'h15);
    rd(a_cause, 32'h00, "all flags cleared");
  endtask

  task automatic t_soft();
    wr(a_soft, 8'h01);
    no_rst(10, "trigger without key");
    cpu.prot_wr(a_soft, 8'h01);
    chk("halt before reset", 32'h1, {31'h0, cpu_halt_o});
    @(posedge clk_i);
    chk("soft reset issued", 32'h1, {31'h0, sys_rst_o});
    @(posedge clk_i);
    chk("soft reset ends", 32'h0, {31'h0, sys_rst_o});
    rd(a_soft, 32'h0, "trigger self-cleared");
    rd(a_cause, 32'h20, "software flag");
  endtask

  task automatic t_refused();
    tick_run <= 1'b1;
    cpu.prot_wr(a_ctrl, 8'h06);
    wr(a_ctrl, 8'h03);
    lock_fuse_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    cpu.prot_wr(a_ctrl, 8'h03);
    cpu.prot_wr(a_win, 8'h07);
    rd(a_win, 32'h0A, "locked window ctrl");
    cpu.prot_wr(a_win, 8'h01);
    no_rst(300, "refused enables");
    lock_fuse_i <= 1'b0;
    tick_run <= 1'b0;
  endtask

  task automatic t_normal();
    cpu.prot_wr(a_ctrl, 8'h07);
    rd(a_stat, 32'h1, "sync pending");
    tick_run <= 1'b1;
    repeat (3) begin
      no_rst(128, "restarted watchdog");
      cpu.restart();
    end
    rd(a_stat, 32'h0, "sync done");
    no_rst(200, "early bite");
    bite(200, "normal bite");
    repeat (110) @(posedge clk_i);
    rd(a_cause, 32'h28, "watchdog flag");
  endtask

  task automatic t_window();
    cpu.prot_wr(a_win, 8'h03);
    cpu.prot_wr(a_ctrl, 8'h03);
    no_rst(176, "closed then open");
    cpu.restart();
    no_rst(224, "open follows closed");
    bite(100, "window total bite");
    repeat (110) @(posedge clk_i);
    cpu.prot_wr(a_win, 8'h03);
    cpu.prot_wr(a_ctrl, 8'h03);
    cpu.restart();
    bite(20, "closed window restart");
    repeat (110) @(posedge clk_i);
  endtask

  task automatic t_again();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(a_cause, 32'h01, "flags after power-up");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_i = 1'b1;
    ext_rst_n_i = 1'b1;
    bod_i = 1'b0;
    dbg_rst_i = 1'b0;
    lock_fuse_i = 1'b0;
    tick_run = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_boot();
    t_pin();
    t_levels();
    t_w1c();
    t_soft();
    t_refused();
    t_normal();
    t_window();
    t_again();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
